// ==== rtl/tlbm_match.sv ====
// Purpose: tlb entry storage, address match and permission check
// Assumes: core request on ref_clk, apb on ref_clk
// Notes: one cycle from request to registered answer
`timescale 1ns/1ps
`include "tlbm_defs.svh"
module tlbm_match (
    // clock and resets
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic manual_reset_n,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // core lookup
    input wire tlbm_pkg::tlbm_req_type lookup_req,
    output tlbm_pkg::tlbm_rsp_type lookup_rsp
);

    ////////////////////////////////////////////////////////////////////
    // storage

    tlbm_pkg::tlbm_entry_type entry_q [`TLBM_ENTRIES];
    logic [`TLBM_ENTRIES-1:0] valid_q;
    logic single_mode_q;
    logic [`TLBM_SPACE_W-1:0] space_q;
    logic [`TLBM_IDX_W-1:0] index_q;
    logic [31:0] hi_q;
    logic [31:0] flags_q;
    logic [2:0] status_q;
    tlbm_pkg::tlbm_rsp_type rsp_q;
    tlbm_pkg::tlbm_state_type state_q;
    logic mrst_s1_q;
    logic mrst_s2_q;
    logic mrst_s3_q;
    logic mrst_active_q;

    ////////////////////////////////////////////////////////////////////
    // manual reset pin: three flops, act when the last two agree

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            mrst_s1_q <= 1'b1;
            mrst_s2_q <= 1'b1;
            mrst_s3_q <= 1'b1;
        end else begin
            mrst_s1_q <= manual_reset_n;
            mrst_s2_q <= mrst_s1_q;
            mrst_s3_q <= mrst_s2_q;
        end
    end

    // filtered level; a one-cycle glitch never reaches the state
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            mrst_active_q <= 1'b0;
        end else if (mrst_s2_q == mrst_s3_q) begin
            mrst_active_q <= ~mrst_s3_q;
        end
    end

    // state tells whether control registers are held in manual reset
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            state_q <= tlbm_pkg::TLBM_RUN;
        end else begin
            case (state_q)
                tlbm_pkg::TLBM_RUN: begin
                    if (mrst_active_q) begin
                        state_q <= tlbm_pkg::TLBM_MRST;
                    end
                end
                tlbm_pkg::TLBM_MRST: begin
                    if (!mrst_active_q) begin
                        state_q <= tlbm_pkg::TLBM_RUN;
                    end
                end
                default: begin
                    state_q <= tlbm_pkg::TLBM_RUN;
                end
            endcase
        end
    end

    logic in_mrst;
    assign in_mrst = (state_q == tlbm_pkg::TLBM_MRST);

    ////////////////////////////////////////////////////////////////////
    // apb decode

    logic wr_en;
    logic rd_en;
    logic addr_ok;
    assign wr_en = psel & penable & pwrite;
    assign rd_en = psel & penable & ~pwrite;
    assign pready = 1'b1; // zero wait states, every access ends in one cycle

    always_comb begin
        case (paddr)
            `TLBM_OFF_CTRL, `TLBM_OFF_SPACE, `TLBM_OFF_INDEX, `TLBM_OFF_HI,
            `TLBM_OFF_LO, `TLBM_OFF_FLAGS, `TLBM_OFF_STATUS: begin
                addr_ok = 1'b1;
            end
            default: begin
                addr_ok = 1'b0;
            end
        endcase
    end

    // unmapped addresses answer with an error during the access phase
    assign pslverr = psel & penable & ~addr_ok;

    // control registers; manual reset clears them but not the entries
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            single_mode_q <= 1'b0;
            space_q <= '0;
            index_q <= '0;
            hi_q <= '0;
            flags_q <= '0;
        end else if (in_mrst) begin
            single_mode_q <= 1'b0;
            space_q <= '0;
            index_q <= '0;
            hi_q <= '0;
            flags_q <= '0;
        end else if (wr_en) begin
            case (paddr)
                `TLBM_OFF_CTRL: begin
                    single_mode_q <= pwdata[`TLBM_CTRL_SVM];
                end
                `TLBM_OFF_SPACE: begin
                    space_q <= pwdata[`TLBM_SPACE_W-1:0];
                end
                `TLBM_OFF_INDEX: begin
                    index_q <= pwdata[`TLBM_IDX_W-1:0];
                end
                `TLBM_OFF_HI: begin
                    hi_q <= pwdata;
                end
                `TLBM_OFF_FLAGS: begin
                    flags_q <= pwdata;
                end
                default: begin
                    hi_q <= hi_q;
                end
            endcase
        end
    end

    logic commit;
    assign commit = wr_en & (paddr == `TLBM_OFF_LO) & ~in_mrst;

    ////////////////////////////////////////////////////////////////////
    // entry array; writing lo commits staged hi and flags to the index

    genvar g;
    generate
        for (g = 0; g < `TLBM_ENTRIES; g++) begin : g_entry
            // power-on clears valid; manual reset does not reach it
            always_ff @(posedge ref_clk or negedge reset_n) begin
                if (!reset_n) begin
                    valid_q[g] <= 1'b0;
                end else if (commit && index_q == (`TLBM_IDX_W)'(g)) begin
                    valid_q[g] <= hi_q[`TLBM_HI_VALID];
                end
            end

            // data part has no reset, like a ram
            always_ff @(posedge ref_clk) begin
                if (commit && index_q == (`TLBM_IDX_W)'(g)) begin
                    entry_q[g].vpn_hi <= hi_q[`TLBM_HI_VPN_HI];
                    entry_q[g].vpn_lo <= hi_q[`TLBM_HI_VPN_LO];
                    entry_q[g].space_identifier <= hi_q[`TLBM_HI_SPACE];
                    entry_q[g].physical_page_number <= pwdata[`TLBM_LO_PPN];
                    entry_q[g].protection_key <= flags_q[`TLBM_FL_KEY];
                    entry_q[g].page_size_bit <= flags_q[`TLBM_FL_SZ];
                    entry_q[g].cacheable <= flags_q[`TLBM_FL_C];
                    entry_q[g].share_bit <= flags_q[`TLBM_FL_SH];
                    entry_q[g].dirty <= flags_q[`TLBM_FL_D];
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////
    // apb read mux; entry views show the selected entry, not staging

    tlbm_pkg::tlbm_entry_type sel_e;
    assign sel_e = entry_q[index_q];

    always_comb begin
        prdata = '0;
        if (rd_en) begin
            case (paddr)
                `TLBM_OFF_CTRL: begin
                    prdata[`TLBM_CTRL_SVM] = single_mode_q;
                end
                `TLBM_OFF_SPACE: begin
                    prdata[`TLBM_SPACE_W-1:0] = space_q;
                end
                `TLBM_OFF_INDEX: begin
                    prdata[`TLBM_IDX_W-1:0] = index_q;
                end
                `TLBM_OFF_HI: begin
                    prdata[`TLBM_HI_VPN_HI] = sel_e.vpn_hi;
                    prdata[`TLBM_HI_VPN_LO] = sel_e.vpn_lo;
                    prdata[`TLBM_HI_SPACE] = sel_e.space_identifier;
                    prdata[`TLBM_HI_VALID] = valid_q[index_q];
                end
                `TLBM_OFF_LO: begin
                    prdata[`TLBM_LO_PPN] = sel_e.physical_page_number;
                end
                `TLBM_OFF_FLAGS: begin
                    prdata[`TLBM_FL_KEY] = sel_e.protection_key;
                    prdata[`TLBM_FL_SZ] = sel_e.page_size_bit;
                    prdata[`TLBM_FL_C] = sel_e.cacheable;
                    prdata[`TLBM_FL_SH] = sel_e.share_bit;
                    prdata[`TLBM_FL_D] = sel_e.dirty;
                end
                `TLBM_OFF_STATUS: begin
                    prdata[2:0] = status_q;
                end
                default: begin
                    prdata = '0;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////
    // lookup: index, compare, permission

    tlbm_pkg::tlbm_entry_type le;
    logic l_valid;
    logic vpn_match;
    logic need_space;
    logic space_ok;
    logic hit;
    logic allowed;
    logic [31:0] pa;

    assign le = entry_q[lookup_req.vaddr[`TLBM_VA_IDX]];
    assign l_valid = valid_q[lookup_req.vaddr[`TLBM_VA_IDX]];

    // 4-kbyte pages skip bits 11-10, leaving the 15 compared bits 31-17 above the index
    assign vpn_match = (le.vpn_hi == lookup_req.vaddr[`TLBM_VA_HI])
        && (le.page_size_bit || le.vpn_lo == lookup_req.vaddr[`TLBM_VA_LO]);

    // single mode shares identifiers only for privileged accesses
    assign need_space = ~le.share_bit
        && (~single_mode_q || lookup_req.user_mode);
    assign space_ok = ~need_space || (le.space_identifier == space_q);
    assign hit = l_valid && vpn_match && space_ok;

    always_comb begin
        case (le.protection_key)
            `TLBM_KEY_PRIV_RD: begin
                allowed = ~lookup_req.write && ~lookup_req.user_mode;
            end
            `TLBM_KEY_ALL_RD: begin
                allowed = ~lookup_req.write;
            end
            `TLBM_KEY_PRIV_RW: begin
                allowed = ~lookup_req.user_mode;
            end
            `TLBM_KEY_ALL_RW: begin
                allowed = 1'b1;
            end
            default: begin
                allowed = 1'b0;
            end
        endcase
    end

    // page offset width follows the page size; the physical bus is 32 bits, so
    // page number bits above those that fit are kept and read back, not driven out
    always_comb begin
        if (le.page_size_bit) begin
            pa = {le.physical_page_number[`TLBM_PPN_4K],
                  lookup_req.vaddr[`TLBM_VA_OFS4K]};
        end else begin
            pa = {le.physical_page_number[`TLBM_PPN_1K],
                  lookup_req.vaddr[`TLBM_VA_OFS1K]};
        end
    end

    // answer registered one cycle after the request
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            rsp_q <= '0;
        end else begin
            rsp_q.valid <= lookup_req.valid;
            rsp_q.hit <= lookup_req.valid && hit;
            rsp_q.fault <= lookup_req.valid && hit && ~allowed;
            rsp_q.paddr <= hit ? pa : '0;
            rsp_q.cacheable <= hit && le.cacheable;
            rsp_q.dirty <= hit && le.dirty;
        end
    end

    assign lookup_rsp = rsp_q;

    // status keeps the outcome of the latest lookup for software
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            status_q <= '0;
        end else if (in_mrst) begin
            status_q <= '0;
        end else if (lookup_req.valid) begin
            status_q[`TLBM_ST_HIT] <= hit;
            status_q[`TLBM_ST_FAULT] <= hit && ~allowed;
            status_q[`TLBM_ST_MISS] <= ~hit;
        end
    end

endmodule : tlbm_match

// ==== rtl/tlbm_defs.svh ====
// Purpose: constants of the tlb entry match block
// Assumes: apb byte addresses, 32-bit data
// Notes: entry fields are written through staging registers, except the page number taken from the lo write
`ifndef TLBM_DEFS_SVH
`define TLBM_DEFS_SVH

// register byte offsets
`define TLBM_OFF_CTRL 12'h000
`define TLBM_OFF_SPACE 12'h004
`define TLBM_OFF_INDEX 12'h008
`define TLBM_OFF_HI 12'h00c
`define TLBM_OFF_LO 12'h010
`define TLBM_OFF_FLAGS 12'h014
`define TLBM_OFF_STATUS 12'h018

// field positions
`define TLBM_CTRL_SVM 0
`define TLBM_HI_VPN_HI 14:0
`define TLBM_HI_VPN_LO 16:15
`define TLBM_HI_SPACE 24:17
`define TLBM_HI_VALID 25
`define TLBM_LO_PPN 28:0
`define TLBM_FL_KEY 1:0
`define TLBM_FL_SZ 2
`define TLBM_FL_C 3
`define TLBM_FL_SH 4
`define TLBM_FL_D 5
`define TLBM_ST_HIT 0
`define TLBM_ST_FAULT 1
`define TLBM_ST_MISS 2

// virtual address and page number slices
`define TLBM_VA_HI 31:17
`define TLBM_VA_IDX 16:12
`define TLBM_VA_LO 11:10
`define TLBM_VA_OFS4K 11:0
`define TLBM_VA_OFS1K 9:0
`define TLBM_PPN_1K 21:0
`define TLBM_PPN_4K 21:2

// protection key codes
`define TLBM_KEY_PRIV_RD 2'b00
`define TLBM_KEY_ALL_RD 2'b01
`define TLBM_KEY_PRIV_RW 2'b10
`define TLBM_KEY_ALL_RW 2'b11

// sizes
`define TLBM_ENTRIES 32
`define TLBM_IDX_W 5
`define TLBM_SPACE_W 8
`define TLBM_PPN_W 29

`endif

// ==== rtl/tlbm_pkg.sv ====
// Purpose: types of the tlb entry match block
// Assumes: tlbm_defs.svh gives the widths
// Notes: valid bits live outside the entry struct
`include "tlbm_defs.svh"
package tlbm_pkg;
    typedef struct packed {
        logic [14:0] vpn_hi;
        logic [1:0] vpn_lo;
        logic [`TLBM_SPACE_W-1:0] space_identifier;
        logic [`TLBM_PPN_W-1:0] physical_page_number;
        logic [1:0] protection_key;
        logic page_size_bit;
        logic cacheable;
        logic share_bit;
        logic dirty;
    } tlbm_entry_type;

    typedef struct packed {
        logic valid;
        logic [31:0] vaddr;
        logic write;
        logic user_mode;
    } tlbm_req_type;

    typedef struct packed {
        logic valid;
        logic hit;
        logic fault;
        logic [31:0] paddr;
        logic cacheable;
        logic dirty;
    } tlbm_rsp_type;

    typedef enum logic [1:0] {
        TLBM_RUN = 2'b01,
        TLBM_MRST = 2'b10
    } tlbm_state_type;
endpackage : tlbm_pkg

// ==== test/tlbm_match_asserts.sv ====
// Purpose: port checks of tlbm_match
// Assumes: one ref_clk domain, reset_n async low
// Notes: bound to the design top
`timescale 1ns/1ps
module tlbm_match_asserts (
    // clock and reset
    input wire logic ref_clk,
    input wire logic reset_n,
    // apb side
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    input wire logic [31:0] prdata,
    // core lookup
    input wire tlbm_pkg::tlbm_req_type lookup_req,
    input wire tlbm_pkg::tlbm_rsp_type lookup_rsp
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!reset_n);
    ////////////////////////////////////////////////////////////////////////////////////
    // a lone request gets a lone answer pulse
    sequence s_one_req;
        lookup_req.valid ##1 !lookup_req.valid;
    endsequence
    sequence s_one_rsp;
        lookup_rsp.valid ##1 !lookup_rsp.valid;
    endsequence
    a_rsp_one_pulse: assert property (s_one_req |-> s_one_rsp)
        else $error("lookup answer not one pulse");
    a_no_spurious: assert property (!lookup_req.valid |=> !lookup_rsp.valid)
        else $error("answer without request");
    a_miss_quiet: assert property (lookup_rsp.valid && !lookup_rsp.hit |->
        lookup_rsp.paddr == 32'h0 && !lookup_rsp.fault) else $error("miss not quiet");
    a_fault_on_hit: assert property (lookup_rsp.fault |-> lookup_rsp.hit)
        else $error("fault without hit");
    // offset bits 9:0 pass untranslated for both page sizes
    a_offset_pass: assert property (lookup_req.valid |=> !lookup_rsp.hit ||
        lookup_rsp.paddr[9:0] == $past(lookup_req.vaddr[9:0])) else $error("offset wrong");
    // every key lets privileged reads through
    a_priv_read_ok: assert property (lookup_req.valid && !lookup_req.write &&
        !lookup_req.user_mode |=> !lookup_rsp.fault) else $error("privileged read fault");
    a_apb_no_wait: assert property (psel && penable |-> pready)
        else $error("apb wait state");
    a_prdata_idle: assert property (!(psel && penable) |-> prdata == 32'h0)
        else $error("read data outside access");
    a_reset_quiet: assert property ($rose(reset_n) |-> !lookup_rsp.valid)
        else $error("answer after reset");
endmodule : tlbm_match_asserts

bind tlbm_match tlbm_match_asserts u_chk (.ref_clk(ref_clk), .reset_n(reset_n),
    .psel(psel), .penable(penable), .pready(pready), .prdata(prdata),
    .lookup_req(lookup_req), .lookup_rsp(lookup_rsp));

// ==== test/tlbm_core_model.sv ====
// Purpose: core side issuing lookups
// Assumes: one request per call
// Notes: released fields show inverted values
`timescale 1ns/1ps
module tlbm_core_model (
    // clock
    input wire logic ref_clk,
    // request to the design
    output tlbm_pkg::tlbm_req_type lookup_req
);
    initial lookup_req = '0;
    // raise for one cycle, then scramble so a stale address never matches by luck;
    // the idle edge after keeps valid from being driven twice in one time step
    task automatic issue(input logic [31:0] va, input logic wr, input logic usr);
        lookup_req <= '{1'b1, va, wr, usr};
        @(posedge ref_clk);
        lookup_req <= '{1'b0, ~va, ~wr, ~usr};
        @(posedge ref_clk);
    endtask : issue
endmodule : tlbm_core_model

// ==== test/tlbm_match_tb.sv ====
// Purpose: self-checking bench of tlbm_match
// Assumes: zero-wait apb, one-cycle lookup answer
// Notes: expected answers are queued by the driver
`timescale 1ns/1ps
module tlbm_match_tb;
    logic ref_clk;
    logic reset_n;
    logic manual_reset_n;
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    tlbm_pkg::tlbm_req_type lookup_req;
    tlbm_pkg::tlbm_rsp_type lookup_rsp;
    tlbm_pkg::tlbm_rsp_type exp_q[$];
    tlbm_pkg::tlbm_rsp_type ex;
    int err_total = 0;
    int n_checks = 0;
    logic [31:0] rnd = 32'h46e36a20;
    logic [31:0] va1;
    logic [31:0] va2;
    logic [31:0] vx;
    logic [28:0] pn1;
    logic [28:0] pn2;
    logic [31:0] rd;
    logic er;
    // allowed bit per {key, write, user}
    localparam logic [15:0] allow_map = 16'hf531;

    tlbm_match DUT (.ref_clk(ref_clk), .reset_n(reset_n), .manual_reset_n(manual_reset_n),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .lookup_req(lookup_req),
        .lookup_rsp(lookup_rsp));
    tlbm_core_model core (.ref_clk(ref_clk), .lookup_req(lookup_req));
    ////////////////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr
    task automatic ck(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_checks++;
        if (g !== e) begin
            err_total++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask : ck
    // one apb transfer, idle edge after so strobes never toggle twice at once
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        do @(posedge ref_clk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge ref_clk);
    endtask : apb
    task automatic prog(input logic [4:0] ix, input logic [31:0] va, input logic [7:0] sp,
        input logic v, input logic [5:0] fl, input logic [28:0] pn);
        apb(1'b1, 12'h008, {27'h0, ix});
        apb(1'b1, 12'h00c, {6'h0, v, sp, va[11:10], va[31:17]});
        apb(1'b1, 12'h014, {26'h0, fl});
        apb(1'b1, 12'h010, {3'h0, pn});
    endtask : prog
    task automatic look(input logic [31:0] va, input logic w, input logic u, input logic h,
        input logic f, input logic [31:0] pa, input logic [1:0] cd);
        exp_q.push_back('{1'b1, h, f, pa, cd[1], cd[0]});
        core.issue(va, w, u);
    endtask : look
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : end_of_test
    ////////////////////////////////////////////////////////////////////////////////////
    // clock
    initial begin
        ref_clk = 1'b0;
        forever #4 ref_clk = ~ref_clk;
    end
    // watchdog, far beyond the 175 or so cycles the tests need
    initial begin
        repeat (5000) @(posedge ref_clk);
        err_total++;
        end_of_test();
    end
    // answer monitor takes the oldest note
    always @(posedge ref_clk) begin
        if (lookup_rsp.valid === 1'b1 && exp_q.size() == 0) begin
            err_total++;
            $display("CHECK FAILED answer note expected none seen valid answer");
        end else if (lookup_rsp.valid === 1'b1) begin
            ex = exp_q.pop_front();
            ck("hit fault", {30'h0, ex.hit, ex.fault}, {30'h0, lookup_rsp.hit, lookup_rsp.fault});
            ck("paddr", ex.paddr, lookup_rsp.paddr);
            if (ex.hit) begin
                ck("cache dirty", {30'h0, ex.cacheable, ex.dirty},
                    {30'h0, lookup_rsp.cacheable, lookup_rsp.dirty});
            end
        end
    end
    // main sequence
    initial begin
        reset_n = 1'b0;
        manual_reset_n = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h0;
        pwdata = 32'h0;
        repeat (3) @(posedge ref_clk);
        reset_n <= 1'b1;
        @(posedge ref_clk);
        rnd = lfsr(rnd);
        look(rnd, 1'b0, 1'b0, 1'b0, 1'b0, 32'h0, 2'b00);
        apb(1'b0, 12'h018, 32'h0);
        ck("status", 32'h4, rd);
        apb(1'b0, 12'h01c, 32'h0);
        ck("unmapped", 32'h1, {31'h0, er});
        $display("test reset done");
        rnd = lfsr(rnd);
        va1 = {rnd[31:17], 5'h03, rnd[11:0]};
        rnd = lfsr(rnd);
        pn1 = rnd[28:0];
        prog(5'h03, va1, 8'h5a, 1'b1, 6'b001011, pn1);
        apb(1'b0, 12'h010, 32'h0);
        ck("ppn readback", {3'h0, pn1}, rd);
        apb(1'b1, 12'h004, 32'h5a);
        look(va1, 1'b0, 1'b0, 1'b1, 1'b0, {pn1[21:0], va1[9:0]}, 2'b10);
        look(va1 ^ 32'h400, 1'b0, 1'b0, 1'b0, 1'b0, 32'h0, 2'b00);
        look(va1 ^ 32'h20000, 1'b0, 1'b0, 1'b0, 1'b0, 32'h0, 2'b00);
        apb(1'b1, 12'h004, 32'h33);
        look(va1, 1'b0, 1'b0, 1'b0, 1'b0, 32'h0, 2'b00);
        apb(1'b1, 12'h000, 32'h1);
        look(va1, 1'b0, 1'b0, 1'b1, 1'b0, {pn1[21:0], va1[9:0]}, 2'b10);
        look(va1, 1'b0, 1'b1, 1'b0, 1'b0, 32'h0, 2'b00);
        apb(1'b1, 12'h000, 32'h0);
        $display("test match done");
        rnd = lfsr(rnd);
        va2 = {rnd[31:17], 5'h07, rnd[11:0]};
        rnd = lfsr(rnd);
        pn2 = rnd[28:0];
        vx = va2 ^ 32'hc00;
        // shared 4k page, every key against every access kind
        for (int k = 0; k < 16; k++) begin
            if (k[1:0] == 2'b00) begin
                prog(5'h07, va2, 8'hc4, 1'b1, {4'b1101, k[3:2]}, pn2);
            end
            look(vx, k[1], k[0], 1'b1, !allow_map[k], {pn2[21:2], vx[11:0]}, 2'b01);
        end
        $display("test keys done");
        manual_reset_n <= 1'b0;
        repeat (6) @(posedge ref_clk);
        manual_reset_n <= 1'b1;
        repeat (8) @(posedge ref_clk);
        apb(1'b0, 12'h004, 32'h0);
        ck("space after manual reset", 32'h0, rd);
        look(vx, 1'b1, 1'b1, 1'b1, 1'b0, {pn2[21:2], vx[11:0]}, 2'b01);
        prog(5'h07, va2, 8'hc4, 1'b0, 6'b111111, pn2);
        look(vx, 1'b0, 1'b0, 1'b0, 1'b0, 32'h0, 2'b00);
        reset_n <= 1'b0;
        repeat (2) @(posedge ref_clk);
        reset_n <= 1'b1;
        @(posedge ref_clk);
        apb(1'b1, 12'h004, 32'h5a);
        look(va1, 1'b0, 1'b0, 1'b0, 1'b0, 32'h0, 2'b00);
        repeat (3) @(posedge ref_clk);
        ck("queue empty", 32'h0, 32'(exp_q.size()));
        $display("test resets done");
        end_of_test();
    end
endmodule : tlbm_match_tb
